//--- verilog/purs_pkg.sv
// constants, types and timing for the power-up reset sequencer
// Behaviour
// - While power-on sense is low the device stays in system reset with all pins high-impedance.
// - The rising edge of power-on sense releases the primary PLL while the rest stays in reset.
// - After that edge the internal resets stay asserted for a further 60 ms for PLL lock.
// - When the lock delay ends the internal resets drop and the processor may boot.
// - Leaving reset enters normal power mode with processor clocks at full rate and resets off.
// - Most non-processor clocks default off with resets held until processor software frees them.
// - The same defaults are applied on every system reset that happens without a power cycle.
// - A power-loss warning on supply-good commands a mirror park and then resets the system.
// - With mirror arrays of revision B or later supply-good is not used as an early warning.
// - All sequencer timing is taken from the reference clock.
// - The primary PLL is reset only by a power-up reset and runs through all other resets.
// - Power-up, supply-good loss and watchdog timeout all lead to the same default state.
package purs_pkg;

  // clock rate of clk
  localparam int CLK_HZ = 200_000_000;
  localparam int CLK_PERIOD_NS = 5;

  // pll lock delay, a least time: exact at this rate, but CLK_HZ / 1000 truncates
  localparam int LOCK_DELAY_MS = 60;
  localparam int LOCK_CYCLES = LOCK_DELAY_MS * (CLK_HZ / 1000);

  // hold time of a warm system reset, a least time: rounds up
  localparam int SYSRST_HOLD_NS = 1000;
  localparam int SYSRST_CYCLES = (SYSRST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // longest wait for the park to finish, a longest time: rounds down
  localparam int PARK_TIMEOUT_NS = 2000;
  localparam int PARK_CYCLES = PARK_TIMEOUT_NS / CLK_PERIOD_NS;

  // number of software-released non-processor clock domains
  localparam int PERIPH_N = 4;

  // sequencer states
  typedef enum logic [2:0] {
    ST_OFF,
    ST_PLL_LOCK,
    ST_RUN,
    ST_PARK,
    ST_SYSRST
  } purs_state_t;

  // cause of the last system reset
  typedef enum logic [1:0] {
    CAUSE_POWERUP,
    CAUSE_SUPPLY,
    CAUSE_WATCHDOG
  } purs_cause_t;

  // device-level clock, reset and pin controls
  typedef struct packed {
    logic pllReset;
    logic sysReset;
    logic cpuReset;
    logic cpuClkEn;
    logic cpuClkFull;
    logic ioHighZ;
    logic parkReq;
  } purs_ctrl_t;

  // value of the controls while power is off
  localparam purs_ctrl_t CTRL_OFF = '{
    pllReset: 1'b1, sysReset: 1'b1, cpuReset: 1'b1, cpuClkEn: 1'b0,
    cpuClkFull: 1'b0, ioHighZ: 1'b1, parkReq: 1'b0};

endpackage

//--- verilog/purs_sync.sv
// two-stage synchroniser for asynchronous level inputs
`timescale 1ns/10ps
`default_nettype none
module purs_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // meta_q feeds only q; nothing else may look at it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule
`default_nettype wire

//--- verilog/purs_sequencer.sv
// power-up and power-loss reset sequencer top
`timescale 1ns/10ps
`default_nettype none
module purs_sequencer #(
  parameter int LOCK_CNT = purs_pkg::LOCK_CYCLES,
  parameter int PERIPH_W = purs_pkg::PERIPH_N
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // power monitor
  input wire logic powerOnSense,
  input wire logic supplyGoodWarning,
  input wire logic mirrorRevB,
  // reset sources and handshakes
  input wire logic watchdogExpire,
  input wire logic parkDone,
  // processor software release of other clocks
  input wire logic [PERIPH_W-1:0] periphRelease,
  // controls
  output purs_pkg::purs_ctrl_t ctrl,
  output logic [PERIPH_W-1:0] periphClkEn,
  output logic [PERIPH_W-1:0] periphReset,
  output purs_pkg::purs_cause_t lastCause
);
  import purs_pkg::*;

  // the shared counter must cover the longest of the three spans
  localparam int SPAN_A = (LOCK_CNT > PARK_CYCLES) ? LOCK_CNT : PARK_CYCLES;
  localparam int SPAN_MAX = (SPAN_A > SYSRST_CYCLES) ? SPAN_A : SYSRST_CYCLES;
  localparam int CNT_W = $clog2(SPAN_MAX + 1);
  localparam int PARK_BOUND = PARK_CYCLES + 2;

  // sense low clears the sequencer at once, without waiting for a clock
  logic rstSense;
  assign rstSense = reset | ~powerOnSense;

  logic senseSync;
  logic goodSync;
  logic senseSeen_q;
  logic senseRise;
  logic warnEvt;
  purs_state_t state_q;
  purs_state_t state_d;
  logic [CNT_W-1:0] cnt_q;
  logic cntClr;
  purs_ctrl_t ctrl_d;

  // true once a counter has reached the last cycle of a span, and past it,
  // so a reset held for a late supply can still leave after recovery
  function automatic logic atLimit(input logic [CNT_W-1:0] c, input int lim);
    atLimit = (c >= CNT_W'(lim - 1));
  endfunction

  // both monitor inputs are asynchronous to clk
  purs_sync #(
    .W(2)
  ) u_sync (
    .clk(clk),
    .reset(reset),
    .d({powerOnSense, supplyGoodWarning}),
    .q({senseSync, goodSync})
  );

  // edge memory is cleared by sense low, so each power-up gives one rise
  always_ff @(posedge clk or posedge rstSense) begin
    if (rstSense) begin
      senseSeen_q <= 1'b0;
    end else begin
      senseSeen_q <= senseSync;
    end
  end

  assign senseRise = senseSync & ~senseSeen_q;
  // revision B arrays ignore supply-good as a warning
  assign warnEvt = ~goodSync & ~mirrorRevB;

  // next state of the sequencer
  always_comb begin
    state_d = state_q;
    cntClr = 1'b0;
    case (state_q)
      ST_OFF: begin
        if (senseRise) begin
          state_d = ST_PLL_LOCK;
          cntClr = 1'b1;
        end
      end
      ST_PLL_LOCK: begin
        if (atLimit(cnt_q, LOCK_CNT)) begin
          state_d = ST_RUN;
          cntClr = 1'b1;
        end
      end
      ST_RUN: begin
        if (warnEvt) begin
          state_d = ST_PARK;
          cntClr = 1'b1;
        end else if (watchdogExpire) begin
          state_d = ST_SYSRST;
          cntClr = 1'b1;
        end
      end
      ST_PARK: begin
        // a stuck park must not keep the device running on failing supplies
        if (parkDone || atLimit(cnt_q, PARK_CYCLES)) begin
          state_d = ST_SYSRST;
          cntClr = 1'b1;
        end
      end
      ST_SYSRST: begin
        // after a supply warning, stay in reset until the supply recovers
        if (atLimit(cnt_q, SYSRST_CYCLES) && (lastCause != CAUSE_SUPPLY || !warnEvt)) begin
          state_d = ST_RUN;
          cntClr = 1'b1;
        end
      end
      default: begin
        state_d = ST_OFF;
        cntClr = 1'b1;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or posedge rstSense) begin
    if (rstSense) begin
      state_q <= ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // one shared span counter; saturates so it never wraps in a state
  always_ff @(posedge clk or posedge rstSense) begin
    if (rstSense) begin
      cnt_q <= '0;
    end else if (cntClr) begin
      cnt_q <= '0;
    end else if (state_q != ST_OFF && state_q != ST_RUN && !atLimit(cnt_q, SPAN_MAX)) begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  // control values decoded from the next state, so outputs leave flops
  always_comb begin
    ctrl_d = CTRL_OFF;
    case (state_d)
      ST_OFF: begin
        ctrl_d = CTRL_OFF;
      end
      ST_PLL_LOCK: begin
        ctrl_d.pllReset = 1'b0;
      end
      ST_RUN: begin
        ctrl_d.pllReset = 1'b0;
        ctrl_d.sysReset = 1'b0;
        ctrl_d.cpuReset = 1'b0;
        ctrl_d.cpuClkEn = 1'b1;
        ctrl_d.cpuClkFull = 1'b1;
      end
      ST_PARK: begin
        // the park needs clocks and pins alive, so the system keeps running
        ctrl_d.pllReset = 1'b0;
        ctrl_d.sysReset = 1'b0;
        ctrl_d.cpuReset = 1'b0;
        ctrl_d.cpuClkEn = 1'b1;
        ctrl_d.cpuClkFull = 1'b1;
        ctrl_d.ioHighZ = 1'b0;
        ctrl_d.parkReq = 1'b1;
      end
      ST_SYSRST: begin
        ctrl_d.pllReset = 1'b0;
      end
      default: begin
        ctrl_d = CTRL_OFF;
      end
    endcase
    // pins leave high-impedance as soon as the next state is normal mode, in the same cycle the resets drop
    if (state_d == ST_RUN) begin
      ctrl_d.ioHighZ = 1'b0;
    end
  end

  // device controls
  always_ff @(posedge clk or posedge rstSense) begin
    if (rstSense) begin
      ctrl <= CTRL_OFF;
    end else begin
      ctrl <= ctrl_d;
    end
  end

  // other clocks stay off until software frees them, and drop on any reset
  always_ff @(posedge clk or posedge rstSense) begin
    if (rstSense) begin
      periphClkEn <= '0;
      periphReset <= '1;
    end else if (state_d == ST_RUN && state_q == ST_RUN) begin
      periphClkEn <= periphRelease;
      periphReset <= ~periphRelease;
    end else begin
      periphClkEn <= '0;
      periphReset <= '1;
    end
  end

  // cause of the last reset; power-up is implied by an async clear
  always_ff @(posedge clk or posedge rstSense) begin
    if (rstSense) begin
      lastCause <= CAUSE_POWERUP;
    end else if (state_q == ST_RUN && state_d == ST_PARK) begin
      lastCause <= CAUSE_SUPPLY;
    end else if (state_q == ST_RUN && state_d == ST_SYSRST) begin
      lastCause <= CAUSE_WATCHDOG;
    end
  end

  // checks
  a_off_held: assert property (@(posedge clk) disable iff (rstSense)
    state_q == ST_OFF |-> ctrl.sysReset && ctrl.ioHighZ && ctrl.pllReset)
    else $error("off state without full reset");

  a_pll_release: assert property (@(posedge clk) disable iff (rstSense)
    state_q == ST_OFF && senseRise |=> !ctrl.pllReset && ctrl.sysReset && ctrl.cpuReset)
    else $error("pll not released alone on sense rise");

  a_lock_hold: assert property (@(posedge clk) disable iff (rstSense)
    state_q == ST_PLL_LOCK && !atLimit(cnt_q, LOCK_CNT) |=> ctrl.sysReset && ctrl.cpuReset)
    else $error("reset dropped before lock delay");

  a_lock_end: assert property (@(posedge clk) disable iff (rstSense)
    state_q == ST_PLL_LOCK && atLimit(cnt_q, LOCK_CNT)
    |=> !ctrl.sysReset && !ctrl.cpuReset && ctrl.cpuClkFull && state_q == ST_RUN)
    else $error("reset not released at end of lock delay");

  a_periph_dflt: assert property (@(posedge clk) disable iff (rstSense)
    state_q != ST_RUN |=> periphClkEn == '0 && periphReset == '1)
    else $error("other clocks not at default after reset");

  a_pll_kept: assert property (@(posedge clk) disable iff (rstSense)
    state_q == ST_RUN ##1 state_q == ST_SYSRST |-> !ctrl.pllReset && ctrl.sysReset)
    else $error("pll reset by a warm reset");

  a_park_first: assert property (@(posedge clk) disable iff (rstSense)
    state_q == ST_RUN && warnEvt |=> ctrl.parkReq && !ctrl.sysReset)
    else $error("park not commanded on warning");

  a_park_bound: assert property (@(posedge clk) disable iff (rstSense)
    $rose(ctrl.parkReq) |-> ##[1:PARK_BOUND] (!ctrl.parkReq && ctrl.sysReset))
    else $error("park not followed by system reset in time");

  a_revb_ignore: assert property (@(posedge clk) disable iff (rstSense)
    state_q == ST_RUN && mirrorRevB && !watchdogExpire |=> state_q == ST_RUN)
    else $error("supply-good used as warning on revision B");

  a_wdog_reset: assert property (@(posedge clk) disable iff (rstSense)
    state_q == ST_RUN && !warnEvt && watchdogExpire
    |=> ctrl.sysReset && ctrl.ioHighZ && lastCause == CAUSE_WATCHDOG)
    else $error("watchdog did not reset to defaults");

endmodule
`default_nettype wire

//--- verification/purs_power_monitor.sv
// behavioural external power monitor driving sense and supply-good
`timescale 1ns/10ps
`default_nettype none
module purs_power_monitor #(
  parameter int SETTLE = 8
) (
  // clock
  input wire logic clk,
  // supply state commanded by the bench
  input wire logic supplyOn,
  input wire logic warnLow,
  // monitor outputs
  output logic powerOnSense,
  output logic supplyGoodWarning
);
  int settleCnt_q = 0;

  // count settling cycles once every supply is applied
  always_ff @(posedge clk) begin
    if (!supplyOn) begin
      settleCnt_q <= 0;
    end else if (settleCnt_q < SETTLE) begin
      settleCnt_q <= settleCnt_q + 1;
    end
  end

  // sense drops at once on supply loss, rises only after settling
  assign powerOnSense = supplyOn && (settleCnt_q == SETTLE);
  // high means supplies good, low is the early loss warning
  assign supplyGoodWarning = !warnLow;
endmodule
`default_nettype wire

//--- verification/purs_sequencer_tb_top.sv
// self-checking testbench for the power-up reset sequencer
`timescale 1ns/10ps
`default_nettype none
module purs_sequencer_tb_top;
  import purs_pkg::*;
  localparam int LOCK = 20;
  localparam purs_ctrl_t RUN_C = '{pllReset: 1'b0, sysReset: 1'b0, cpuReset: 1'b0,
    cpuClkEn: 1'b1, cpuClkFull: 1'b1, ioHighZ: 1'b0, parkReq: 1'b0};
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic supplyOn = 1'b0;
  logic warnLow = 1'b0;
  logic mirrorRevB = 1'b0;
  logic watchdogExpire = 1'b0;
  logic parkDone = 1'b0;
  logic [3:0] periphRelease = 4'h0;
  wire logic powerOnSense;
  wire logic supplyGoodWarning;
  purs_ctrl_t ctrl;
  logic [3:0] periphClkEn;
  logic [3:0] periphReset;
  purs_cause_t lastCause;
  int mismatches = 0;
  int checked = 0;
  int n;

  // 200 MHz clock
  always #2.5 clk = ~clk;

  purs_power_monitor i_mon (.clk(clk), .supplyOn(supplyOn), .warnLow(warnLow),
    .powerOnSense(powerOnSense), .supplyGoodWarning(supplyGoodWarning));

  purs_sequencer #(.LOCK_CNT(LOCK), .PERIPH_W(4)) i_dut (.clk(clk), .reset(reset),
    .powerOnSense(powerOnSense), .supplyGoodWarning(supplyGoodWarning),
    .mirrorRevB(mirrorRevB), .watchdogExpire(watchdogExpire), .parkDone(parkDone),
    .periphRelease(periphRelease), .ctrl(ctrl), .periphClkEn(periphClkEn),
    .periphReset(periphReset), .lastCause(lastCause));

  // inputs change 1 ns after the rising edge so the edge's updates land first
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask

  task automatic close_out();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // bounded wait for system reset to reach a level
  task automatic wait_sys(input logic v);
    n = 0;
    while (ctrl.sysReset !== v && n < 2000) begin
      step(1);
      n++;
    end
    bound_hit(2000);
  endtask

  // a bounded wait that ran out ends the run as a failure
  task automatic bound_hit(input int lim);
    if (n >= lim) begin
      mismatches++;
      $display("wrong value at %0t: wait timed out", $time);
      close_out();
    end
  endtask

  // compare a counted number of cycles
  task automatic cmp_cnt(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask

  task automatic t_off();
    step(6);
    cmp(ctrl, CTRL_OFF, "reset defaults");
    cmp(periphReset, 4'hf, "periph resets held");
    reset = 1'b0;
    step(5);
    cmp(ctrl, CTRL_OFF, "sense low holds reset");
    cmp(periphClkEn, 4'h0, "periph clocks off");
    $display("test off done");
  endtask

  task automatic t_powerup();
    supplyOn = 1'b1;
    n = 0;
    while (powerOnSense !== 1'b1 && n < 50) begin
      step(1);
      n++;
    end
    bound_hit(50);
    step(2);
    cmp(ctrl.pllReset, 1'b1, "pll early release");
    step(1);
    cmp({ctrl.pllReset, ctrl.sysReset}, 2'b01, "pll released alone");
    step(LOCK - 1);
    cmp(ctrl.sysReset, 1'b1, "lock delay too short");
    step(1);
    cmp(ctrl, RUN_C, "normal mode");
    periphRelease = 4'h5;
    step(2);
    cmp({periphClkEn, periphReset}, 8'h5a, "software release");
    $display("test powerup done");
  endtask

  task automatic t_watchdog();
    watchdogExpire = 1'b1;
    step(1);
    watchdogExpire = 1'b0;
    cmp({ctrl.pllReset, ctrl.sysReset, ctrl.ioHighZ}, 3'b011, "watchdog reset");
    cmp(lastCause, CAUSE_WATCHDOG, "watchdog cause");
    step(1);
    cmp({periphClkEn, periphReset}, 8'h0f, "periph defaults again");
    wait_sys(1'b0);
    cmp_cnt(n, SYSRST_CYCLES - 1, "warm reset length");
    cmp(ctrl, RUN_C, "back to normal");
    $display("test watchdog done");
  endtask

  task automatic t_warning();
    mirrorRevB = 1'b1;
    warnLow = 1'b1;
    step(8);
    cmp(ctrl, RUN_C, "warning ignored");
    mirrorRevB = 1'b0;
    n = 0;
    while (ctrl.parkReq !== 1'b1 && n < 10) begin
      step(1);
      n++;
    end
    bound_hit(10);
    cmp({ctrl.parkReq, ctrl.sysReset}, 2'b10, "park before reset");
    cmp(lastCause, CAUSE_SUPPLY, "supply cause");
    parkDone = 1'b1;
    step(2);
    parkDone = 1'b0;
    cmp({ctrl.pllReset, ctrl.sysReset, ctrl.ioHighZ, ctrl.parkReq}, 4'h6, "loss reset");
    warnLow = 1'b0;
    wait_sys(1'b0);
    cmp(ctrl, RUN_C, "normal after loss");
    $display("test warning done");
  endtask

  // a park that never reports done must still end in reset, held while supply is low
  task automatic t_parktime();
    warnLow = 1'b1;
    n = 0;
    while (ctrl.parkReq !== 1'b1 && n < 10) begin
      step(1);
      n++;
    end
    bound_hit(10);
    step(PARK_CYCLES - 1);
    cmp(ctrl.parkReq, 1'b1, "park cut short");
    step(1);
    cmp({ctrl.parkReq, ctrl.sysReset}, 2'b01, "park timeout reset");
    step(SYSRST_CYCLES + 4);
    cmp(ctrl.sysReset, 1'b1, "left reset with supply low");
    warnLow = 1'b0;
    wait_sys(1'b0);
    cmp(ctrl, RUN_C, "normal after timeout");
    $display("test parktime done");
  endtask

  task automatic t_senselow();
    supplyOn = 1'b0;
    #1;
    cmp(ctrl, CTRL_OFF, "async reset on sense low");
    step(2);
    cmp(lastCause, CAUSE_POWERUP, "powerup cause");
    $display("test senselow done");
  endtask

  initial begin
    t_off();
    t_powerup();
    t_watchdog();
    t_warning();
    t_parktime();
    t_senselow();
    t_powerup();
    close_out();
  end
endmodule
`default_nettype wire
